/* File: rtl/sbt_top.sv */
// 16-bit up-counter with buffered wide access, trigger reset and overflow flag
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module sbt_top
    import sbt_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                nrst_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic [DATA_W-1:0]   wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic      [DATA_W-1:0]   rdata_out,
    input  wire logic                aux_osc_in,
    input  wire logic                aux_osc_enable_in,
    input  wire sbt_pkg::sbt_trig_t  cmp1_trig_in,
    input  wire sbt_pkg::sbt_trig_t  cmp2_trig_in,
    input  wire logic                adc_enable_in,
    output logic                     adc_start_out,
    output logic                     irq_out,
    output logic                     irq_priority_out,
    output logic      [15:0]         count_out
);
    import sbt_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        logic [15:0]       count;
        logic [DATA_W-1:0] hold;
        logic [DATA_W-1:0] ctrl;
        logic              ovf;
        logic              ovf_en;
        logic              ovf_pri;
        logic [DATA_W-1:0] rdata;
        logic              adc_start;
    } sbt_state_t;

    sbt_state_t st_reg;
    sbt_state_t st_next;

    logic aux_rise;
    logic raw_tick;
    logic inc_tick;
    logic wide;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic trig_hit;
    logic trig_ok;
    logic async_mode;
    logic ovf_set;

    function automatic logic trig_fire(input sbt_trig_t t);
        return t.pulse && (t.mode == MODE_SPECIAL_TRIG);
    endfunction

    function automatic logic [DATA_W-1:0] bit_byte(input logic b, input int pos);
        return DATA_W'({7'h00, b} << pos);
    endfunction

    // ****************************************
    // Count source and prescaler
    // ****************************************
    sbt_sync u_aux_sync
    (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .pin_in     (aux_osc_in),
        .level_out  (),
        .rise_out   (aux_rise)
    );

    // Oscillator counts only when enabled by its own enable input aux_osc_enable_in as well
    assign raw_tick = st_reg.ctrl[BIT_COUNTER_ON]
                      && (st_reg.ctrl[BIT_SOURCE_SEL] ? (aux_rise && aux_osc_enable_in) : 1'b1);

    sbt_prescale u_presc
    (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .tick_in    (raw_tick),
        .clear_in   (wr_low),
        .ratio_in   (st_reg.ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO]),
        .tick_out   (inc_tick)
    );

    // ****************************************
    // Decode
    // ****************************************
    assign wide    = st_reg.ctrl[BIT_WIDE_ACCESS];
    assign wr_low  = wr_in && (addr_in == OFF_COUNT_LOW);
    assign wr_high = wr_in && (addr_in == OFF_COUNT_HIGH);
    assign rd_low  = rd_in && (addr_in == OFF_COUNT_LOW);

    // Unit one follows this counter only with the upper assign bit; unit two with either
    assign trig_hit = (trig_fire(cmp1_trig_in) && st_reg.ctrl[BIT_ASSIGN_HI])
                      || (trig_fire(cmp2_trig_in)
                          && (st_reg.ctrl[BIT_ASSIGN_HI] || st_reg.ctrl[BIT_ASSIGN_LO]));
    // Unsynchronised external counting gives no reset guarantee, so it is dropped there
    assign async_mode = st_reg.ctrl[BIT_SOURCE_SEL] && st_reg.ctrl[BIT_EXT_SYNC];
    assign trig_ok    = trig_hit && !async_mode;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_next           = st_reg;
        st_next.adc_start = trig_fire(cmp2_trig_in) && adc_enable_in;
        st_next.rdata     = BYTE_ZERO;
        ovf_set           = 1'b0;

        if (wr_low)
        begin
            // Write wins over a trigger and an increment in the same cycle
            st_next.count[7:0]  = wdata_in;
            st_next.count[15:8] = wide ? st_reg.hold : st_reg.count[15:8];
        end
        else if (wr_high && !wide)
        begin
            st_next.count[15:8] = wdata_in;
        end
        else if (trig_ok)
        begin
            st_next.count = COUNT_ZERO;
        end
        else if (inc_tick)
        begin
            st_next.count = st_reg.count + COUNT_ONE;
            ovf_set       = (st_reg.count == COUNT_MAX);
        end

        if (wr_high && wide)
        begin
            st_next.hold = wdata_in;
        end
        if (rd_low && wide)
        begin
            st_next.hold = st_reg.count[15:8];
        end

        if (wr_in)
        begin
            case (addr_in)
                OFF_CONTROL:     st_next.ctrl    = wdata_in;
                OFF_FLAGS_TWO:   st_next.ovf     = wdata_in[BIT_OVERFLOW];
                OFF_ENABLES_TWO: st_next.ovf_en  = wdata_in[BIT_OVERFLOW];
                OFF_PRIOR_TWO:   st_next.ovf_pri = wdata_in[BIT_OVERFLOW];
                default:         st_next.ctrl    = st_next.ctrl;
            endcase
        end
        // A new overflow beats a software clear in the same cycle
        if (ovf_set)
        begin
            st_next.ovf = 1'b1;
        end

        if (rd_in)
        begin
            case (addr_in)
                OFF_COUNT_LOW:   st_next.rdata = st_reg.count[7:0];
                OFF_COUNT_HIGH:  st_next.rdata = wide ? st_reg.hold : st_reg.count[15:8];
                OFF_CONTROL:     st_next.rdata = st_reg.ctrl;
                OFF_FLAGS_TWO:   st_next.rdata = bit_byte(st_reg.ovf, BIT_OVERFLOW);
                OFF_ENABLES_TWO: st_next.rdata = bit_byte(st_reg.ovf_en, BIT_OVERFLOW);
                OFF_PRIOR_TWO:   st_next.rdata = bit_byte(st_reg.ovf_pri, BIT_OVERFLOW);
                default:         st_next.rdata = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            st_reg         <= '0;
            st_reg.ctrl    <= CONTROL_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_out        = st_reg.rdata;
    assign count_out        = st_reg.count;
    assign adc_start_out    = st_reg.adc_start;
    assign irq_out          = st_reg.ovf && st_reg.ovf_en;
    assign irq_priority_out = st_reg.ovf_pri;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_high_buffer_map: assert property (
        rd_in && addr_in == OFF_COUNT_HIGH && wide |=> rdata_out == $past(st_reg.hold))
        else $error("high read in wide mode not from buffer");

    a_low_read_snap: assert property (
        rd_low && wide |=> st_reg.hold == $past(st_reg.count[15:8]))
        else $error("low read did not snap high byte");

    a_low_write_load: assert property (
        wr_low && wide |=> count_out == {$past(st_reg.hold), $past(wdata_in)})
        else $error("wide low write did not load both bytes");

    a_high_write_iso: assert property (
        wr_high && wide && !trig_ok && !inc_tick |=> count_out == $past(count_out))
        else $error("wide high write reached counter");

    a_wrap_flag: assert property (
        inc_tick && count_out == COUNT_MAX && !wr_in && !trig_ok |=> count_out == COUNT_ZERO && st_reg.ovf)
        else $error("wrap did not set flag");

    a_irq_gate: assert property (
        !st_reg.ovf_en |-> !irq_out)
        else $error("interrupt while disabled");

    a_trig_reset: assert property (
        trig_ok && !wr_in && !st_reg.ovf |=> count_out == COUNT_ZERO && !st_reg.ovf)
        else $error("trigger reset wrong or set flag");

    a_adc_start: assert property (
        trig_fire(cmp2_trig_in) && adc_enable_in |=> adc_start_out ##1 !adc_start_out || trig_fire($past(cmp2_trig_in)))
        else $error("converter start missing");

    a_write_wins: assert property (
        wr_low && trig_hit |=> count_out[7:0] == $past(wdata_in))
        else $error("trigger beat software write");

    a_hold_off: assert property (
        !st_reg.ctrl[BIT_COUNTER_ON] && !wr_in && !trig_ok |=> $stable(count_out))
        else $error("counter moved while off");

    // ****************************************
    // Register path and counter step checks
    // ****************************************

    a_narrow_high_write: assert property (
        wr_high && !wide |=> count_out[15:8] == $past(wdata_in))
        else $error("narrow high write missed live byte");

    a_narrow_high_read: assert property (
        rd_in && addr_in == OFF_COUNT_HIGH && !wide |=> rdata_out == $past(st_reg.count[15:8]))
        else $error("narrow high read not from live byte");

    a_async_ignore: assert property (
        trig_hit && async_mode && !wr_in && !inc_tick |=> count_out == $past(count_out))
        else $error("trigger acted in async mode");

    a_flag_sticky: assert property (
        st_reg.ovf && !(wr_in && addr_in == OFF_FLAGS_TWO) |=> st_reg.ovf)
        else $error("overflow flag dropped without clear");

    a_flag_set_wins: assert property (
        ovf_set |=> st_reg.ovf)
        else $error("overflow lost against clear");

    a_flag_source: assert property (
        $rose(st_reg.ovf) |-> $past(ovf_set) || $past(wr_in && addr_in == OFF_FLAGS_TWO))
        else $error("flag set by other than wrap or write");

    a_rdata_idle: assert property (
        !rd_in |=> rdata_out == BYTE_ZERO)
        else $error("read data not zero outside read");

    a_adc_gate: assert property (
        !adc_enable_in |=> !adc_start_out)
        else $error("converter start while disabled");

    a_count_step: assert property (
        inc_tick && !wr_low && !(wr_high && !wide) && !trig_ok |=> count_out == $past(count_out) + COUNT_ONE)
        else $error("counter did not step by one");

    a_idle_hold: assert property (
        !inc_tick && !wr_low && !(wr_high && !wide) && !trig_ok |=> $stable(count_out))
        else $error("counter moved without cause");

    a_buffer_write: assert property (
        wr_high && wide |=> st_reg.hold == $past(wdata_in))
        else $error("wide high write missed buffer");

    a_ctrl_write: assert property (
        wr_in && addr_in == OFF_CONTROL |=> st_reg.ctrl == $past(wdata_in))
        else $error("control write lost");

    a_low_read_data: assert property (
        rd_low |=> rdata_out == $past(st_reg.count[7:0]))
        else $error("low read data wrong");

    a_ctrl_read: assert property (
        rd_in && addr_in == OFF_CONTROL |=> rdata_out == $past(st_reg.ctrl))
        else $error("control read data wrong");

    a_flag_read: assert property (
        rd_in && addr_in == OFF_FLAGS_TWO |=> rdata_out[BIT_OVERFLOW] == $past(st_reg.ovf))
        else $error("flag read data wrong");

    a_enable_read: assert property (
        rd_in && addr_in == OFF_ENABLES_TWO |=> rdata_out[BIT_OVERFLOW] == $past(st_reg.ovf_en))
        else $error("enable read data wrong");

    a_unmapped_write: assert property (
        wr_in && addr_in > OFF_PRIOR_TWO |=> $stable(st_reg.ctrl) && $stable(st_reg.ovf_en) && $stable(st_reg.ovf_pri))
        else $error("unmapped write changed a register");


    c_overflow:   cover property (inc_tick && count_out == COUNT_MAX);
    c_trig_reset: cover property (trig_ok && count_out != COUNT_ZERO);
    c_wide_read:  cover property (rd_low && wide ##1 rd_in && addr_in == OFF_COUNT_HIGH);
    c_collision:  cover property (wr_low && trig_hit);
    c_async_trig: cover property (trig_hit && async_mode);

endmodule

/* File: rtl/sbt_pkg.sv */
// Package: register map, field layout and carrier types of the 16-bit timer
package sbt_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_COUNT_LOW   = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH  = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CONTROL     = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_FLAGS_TWO   = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_ENABLES_TWO = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_PRIOR_TWO   = 3'h5;

    // ****************************************
    // Control register fields and overflow flag bit
    // ****************************************
    localparam int BIT_WIDE_ACCESS  = 7;
    localparam int BIT_ASSIGN_HI    = 6;
    localparam int BIT_PRESCALE_HI  = 5;
    localparam int BIT_PRESCALE_LO  = 4;
    localparam int BIT_ASSIGN_LO    = 3;
    localparam int BIT_EXT_SYNC     = 2;
    localparam int BIT_SOURCE_SEL   = 1;
    localparam int BIT_COUNTER_ON   = 0;
    localparam int BIT_OVERFLOW     = 1;

    // ****************************************
    // Reset values and constants
    // ****************************************
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ZERO     = 8'h00;
    localparam logic [15:0]       COUNT_ZERO    = 16'h0000;
    localparam logic [15:0]       COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0]       COUNT_ONE     = 16'h0001;
    localparam logic [3:0]        MODE_SPECIAL_TRIG = 4'hB;
    localparam int                PRESC_W       = 3;

    typedef struct packed
    {
        logic       pulse;
        logic [3:0] mode;
    } sbt_trig_t;

endpackage

/* File: rtl/sbt_sync.sv */
// Three-flop synchroniser with agreement filter and rising-edge output
`timescale 1ns/1ps
module sbt_sync
    import sbt_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic nrst_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out
);
    import sbt_pkg::*;

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sbt_sync_t;

    sbt_sync_t st_reg;
    sbt_sync_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Only stages two and three are looked at; stage one may be metastable
        if (st_reg.s2 == st_reg.s3)
        begin
            st_next.level = st_reg.s3;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;
    assign rise_out  = st_next.level && !st_reg.level;

    a_rise_agree: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        rise_out |-> st_reg.s2 && st_reg.s3)
        else $error("edge reported without agreement");

endmodule

/* File: rtl/sbt_prescale.sv */
// Prescaler: divides count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module sbt_prescale
    import sbt_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       tick_in,
    input  wire logic       clear_in,
    input  wire logic [1:0] ratio_in,
    output logic            tick_out
);
    import sbt_pkg::*;

    typedef struct packed
    {
        logic [PRESC_W-1:0] cnt;
    } sbt_presc_t;

    sbt_presc_t         st_reg;
    sbt_presc_t         st_next;
    logic [PRESC_W-1:0] mask;

    always_comb
    begin
        mask    = PRESC_W'((1 << ratio_in) - 1);
        st_next = st_reg;
        if (clear_in)
        begin
            st_next.cnt = '0;
        end
        else if (tick_in)
        begin
            st_next.cnt = PRESC_W'(st_reg.cnt + 1'b1);
        end
    end

    // A clear swallows the tick of the same cycle so a written value is never bumped at once
    assign tick_out = tick_in && !clear_in && ((st_reg.cnt & mask) == mask);

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    a_presc_clear: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        clear_in |=> st_reg.cnt == '0)
        else $error("prescaler not cleared");

endmodule

/* File: dv/sbt_bench.sv */
// Self-checking bench of the 16-bit timer with buffered wide access
`timescale 1ns/1ps
module sbt_bench;
    import sbt_pkg::*;
    logic              ref_clk_in;
    logic              nrst_in;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              aux;
    logic              aux_en;
    sbt_trig_t         cmp1;
    sbt_trig_t         cmp2;
    logic              adc_en;
    logic              adc_start;
    logic              irq;
    logic              irq_prio;
    logic [15:0]       cnt;
    logic              rd_pend;
    logic [7:0]        exp_q[$];
    logic [31:0]       seed;
    int                n_errors;
    int                checked;

    sbt_top i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .aux_osc_in(aux), .aux_osc_enable_in(aux_en),
        .cmp1_trig_in(cmp1), .cmp2_trig_in(cmp2), .adc_enable_in(adc_en), .adc_start_out(adc_start),
        .irq_out(irq), .irq_priority_out(irq_prio), .count_out(cnt));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask

    // The expected byte is noted at issue and compared by the monitor
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk_in);
        rd <= 1'b0;
    endtask

    task automatic trig(input int u, input logic [3:0] m, input logic a, input logic [15:0] ec,
                        input logic es);
        @(posedge ref_clk_in);
        adc_en <= a;
        if (u == 1)
            cmp1 <= '{1'b1, m};
        else
            cmp2 <= '{1'b1, m};
        @(posedge ref_clk_in);
        cmp1 <= '0;
        cmp2 <= '0;
        @(negedge ref_clk_in);
        check(cnt, ec);
        check({15'h0, adc_start}, {15'h0, es});
    endtask

    task automatic preload();
        wr_reg(OFF_COUNT_HIGH, 8'h12);
        wr_reg(OFF_COUNT_LOW, 8'h55);
    endtask

    // Cycles between two successive counter changes
    task automatic gap(output int n);
        logic [15:0] p;
        int          k;
        @(negedge ref_clk_in);
        p = cnt;
        for (k = 0; k < 40 && cnt === p; k++)
            @(negedge ref_clk_in);
        p = cnt;
        for (n = 1; n < 40; n++)
        begin
            @(negedge ref_clk_in);
            if (cnt !== p)
                break;
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Read-data monitor
    // ****************************************
    always @(posedge ref_clk_in)
        rd_pend <= rd;

    always @(negedge ref_clk_in)
        if (rd_pend === 1'b1)
            check({8'h0, rdata}, {8'h0, exp_q.pop_front()});

    initial
    begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [7:0]  r1;
        logic [7:0]  r2;
        logic [15:0] prv;
        int          n;
        nrst_in = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        aux = 1'b0;
        aux_en = 1'b0;
        cmp1 = '0;
        cmp2 = '0;
        adc_en = 1'b0;
        seed = 32'h3a27ca25;
        n_errors = 0;
        checked = 0;
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd_reg(a[ADDR_W-1:0], 8'h00);
        // Narrow mode: high address is the live byte
        seed = lfsr(seed);
        r1 = seed[7:0];
        r2 = seed[15:8];
        wr_reg(OFF_COUNT_LOW, r1);
        wr_reg(OFF_COUNT_HIGH, r2);
        rd_reg(OFF_COUNT_LOW, r1);
        rd_reg(OFF_COUNT_HIGH, r2);
        check(cnt, {r2, r1});
        wr_reg(3'h7, 8'hA5);
        rd_reg(3'h7, 8'h00);
        // Wide mode goes through the holding buffer
        wr_reg(OFF_CONTROL, 8'h80);
        rd_reg(OFF_CONTROL, 8'h80);
        wr_reg(OFF_COUNT_HIGH, ~r2);
        @(negedge ref_clk_in);
        check(cnt, {r2, r1});
        rd_reg(OFF_COUNT_HIGH, ~r2);
        wr_reg(OFF_COUNT_LOW, 8'h3C);
        @(negedge ref_clk_in);
        check(cnt, {~r2, 8'h3C});
        wr_reg(OFF_COUNT_HIGH, 8'h5A);
        rd_reg(OFF_COUNT_LOW, 8'h3C);
        rd_reg(OFF_COUNT_HIGH, ~r2);
        // Overflow, sticky flag and enable
        wr_reg(OFF_CONTROL, 8'h00);
        wr_reg(OFF_COUNT_HIGH, 8'hFF);
        wr_reg(OFF_COUNT_LOW, 8'hFC);
        wr_reg(OFF_CONTROL, 8'h01);
        prv = cnt;
        for (n = 0; n < 20 && cnt !== 16'h0000; n++)
        begin
            prv = cnt;
            @(negedge ref_clk_in);
        end
        check(prv, 16'hFFFF);
        wr_reg(OFF_CONTROL, 8'h00);
        rd_reg(OFF_FLAGS_TWO, 8'h02);
        check({15'h0, irq}, 16'h0000);
        wr_reg(OFF_ENABLES_TWO, 8'hFF);
        wr_reg(OFF_PRIOR_TWO, 8'hFF);
        @(negedge ref_clk_in);
        check({14'h0, irq, irq_prio}, 16'h0003);
        rd_reg(OFF_ENABLES_TWO, 8'h02);
        wr_reg(OFF_ENABLES_TWO, 8'h00);
        @(negedge ref_clk_in);
        check({15'h0, irq}, 16'h0000);
        wr_reg(OFF_FLAGS_TWO, 8'h00);
        rd_reg(OFF_FLAGS_TWO, 8'h00);
        // Prescale ratios 1, 2, 4, 8
        for (int r = 0; r < 4; r++)
        begin
            wr_reg(OFF_CONTROL, {2'b00, r[1:0], 4'h1});
            gap(n);
            check(n[15:0], 16'(1 << r));
        end
        wr_reg(OFF_CONTROL, 8'h00);
        @(negedge ref_clk_in);
        prv = cnt;
        repeat (5) @(negedge ref_clk_in);
        check(cnt, prv);
        // Special event trigger
        wr_reg(OFF_CONTROL, 8'h40);
        preload();
        trig(1, MODE_SPECIAL_TRIG, 1'b0, 16'h0000, 1'b0);
        preload();
        trig(1, 4'hA, 1'b0, 16'h1255, 1'b0);
        wr_reg(OFF_CONTROL, 8'h08);
        preload();
        trig(1, MODE_SPECIAL_TRIG, 1'b0, 16'h1255, 1'b0);
        for (int m = 0; m < 16; m++)
        begin
            preload();
            trig(2, m[3:0], 1'b1, (m == 11) ? 16'h0000 : 16'h1255, m == 11);
        end
        preload();
        trig(2, MODE_SPECIAL_TRIG, 1'b0, 16'h0000, 1'b0);
        rd_reg(OFF_FLAGS_TWO, 8'h00);
        wr_reg(OFF_CONTROL, 8'h40);
        preload();
        @(posedge ref_clk_in);
        wr <= 1'b1;
        addr <= OFF_COUNT_LOW;
        wdata <= 8'h77;
        cmp1 <= '{1'b1, MODE_SPECIAL_TRIG};
        @(posedge ref_clk_in);
        wr <= 1'b0;
        cmp1 <= '0;
        @(negedge ref_clk_in);
        check(cnt, 16'h1277);
        // Async counter mode drops the trigger
        wr_reg(OFF_CONTROL, 8'h46);
        preload();
        trig(1, MODE_SPECIAL_TRIG, 1'b0, 16'h1255, 1'b0);
        // Oscillator source: one count per rising edge
        wr_reg(OFF_CONTROL, 8'h03);
        for (int e = 1; e >= 0; e--)
        begin
            aux_en <= e[0];
            @(negedge ref_clk_in);
            prv = cnt;
            repeat (5)
            begin
                @(posedge ref_clk_in);
                aux <= 1'b1;
                repeat (5) @(posedge ref_clk_in);
                aux <= 1'b0;
                repeat (5) @(posedge ref_clk_in);
            end
            @(negedge ref_clk_in);
            check(cnt, prv + 16'(5 * e));
        end
        repeat (3) @(posedge ref_clk_in);
        report_and_stop();
    end
endmodule
